// *** verilog/adc_fifo_pkg.sv ***
package adc_fifo_pkg;
  // state flag register
  localparam logic [7:0] STATE_FLAGS_OFFSET = 8'h3b;
  localparam logic [7:0] STATE_FLAGS_RESET = 8'h01;
  localparam int FLAG_ANY_ERR = 7;
  localparam int FLAG_WRITE_CLASH = 6;
  localparam int FLAG_READ_CLASH = 5;
  localparam int FLAG_UPPER = 4;
  localparam int FLAG_LOWER = 3;
  localparam int FLAG_LOST = 2;
  localparam int FLAG_LEVEL = 1;
  localparam int FLAG_DRAINED = 0;
  // sample tag layout
  localparam logic [7:0] TAG_RESET = 8'h00;
  localparam int TAG_LIMIT = 6;
  localparam int TAG_LEVEL = 5;
  localparam int TAG_DRAINED = 4;
  // serial commands
  localparam logic [7:0] BURST_READ_CMD = 8'h7d;
  localparam logic [7:0] REG_READ_BIT = 8'h40;
  localparam logic [7:0] FLAGS_READ_CMD = REG_READ_BIT | STATE_FLAGS_OFFSET;
  // serial unit lengths in clocks, minus one
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [4:0] TAGGED_LAST = 5'h1f;
  localparam logic [4:0] BARE_LAST = 5'h17;
  localparam logic [4:0] CRC_LAST = 5'h0f;
  // link check generator
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha2eb;
  // converter write busy time
  localparam int CLK_PERIOD_NS = 4;
  localparam int WRITE_BUSY_NS = 32;
  localparam logic [3:0] WRITE_BUSY_CYCLES = 4'((WRITE_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [5:0] {
    PH_IDLE = 6'b000001,
    PH_CMD  = 6'b000010,
    PH_CNT  = 6'b000100,
    PH_DATA = 6'b001000,
    PH_CRC  = 6'b010000,
    PH_STAT = 6'b100000
  } phase_type;
endpackage

// *** verilog/adc_sample_fifo.sv ***
`timescale 1ns/1ps
module adc_sample_fifo #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic dout_o,
  input wire logic fifo_enable_i,
  input wire logic stream_mode_i,
  input wire logic [7:0] watermark_i,
  input wire logic tag_append_i,
  input wire logic state_append_i,
  input wire logic link_check_enable_i,
  input wire logic [6:0] int_enable_i,
  input wire logic [15:0] limit_check_enable_i,
  input wire logic [11:0] upper_limit_value_i,
  input wire logic [11:0] lower_limit_value_i,
  input wire logic any_error_i,
  input wire logic conv_valid_i,
  input wire logic [23:0] conv_data_i,
  input wire logic [3:0] input_index_i,
  output logic fifo_int_o,
  output logic [7:0] fifo_state_flags_o,
  output logic [7:0] fifo_sample_tag_o
);
  import adc_fifo_pkg::*;

  localparam int CW = AW + 1;

  // crc step for one serial bit
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic din);
    crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ din) ? CRC_POLY : 16'h0000);
  endfunction

  // pin synchronisers: sclk, cs_n, mosi
  logic [2:0] sync1_ff, sync2_ff, sync3_ff, filt_ff, prev_ff;
  logic [2:0] nxt_filt;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      nxt_filt[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : filt_ff[i];
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_ff <= 3'h7;
      sync2_ff <= 3'h7;
      sync3_ff <= 3'h7;
      filt_ff <= 3'h7;
      prev_ff <= 3'h7;
    end else begin
      sync1_ff <= {sclk_i, cs_n_i, mosi_i};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff <= nxt_filt;
      prev_ff <= filt_ff;
    end
  end

  logic sclk_rise, sclk_fall, cs_high, cs_fall, mosi;
  assign sclk_rise = filt_ff[2] & ~prev_ff[2];
  assign sclk_fall = ~filt_ff[2] & prev_ff[2];
  assign cs_high = filt_ff[1];
  assign cs_fall = ~filt_ff[1] & prev_ff[1];
  assign mosi = filt_ff[0];

  // sample memory, tag in the top byte
  logic [31:0] mem [DEPTH];
  logic mem_we;
  logic [31:0] mem_wdata;

  // main state
  phase_type phase_ff, nxt_phase;
  logic [4:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] in_sreg_ff, nxt_in_sreg;
  logic [31:0] out_sreg_ff, nxt_out_sreg;
  logic [15:0] crc_ff, nxt_crc;
  logic [CW-1:0] remain_ff, nxt_remain;
  logic [CW-1:0] block_ff, nxt_block;
  logic [CW-1:0] count_ff, nxt_count;
  logic [AW-1:0] rd_ptr_ff, nxt_rd_ptr, wr_ptr_ff, nxt_wr_ptr;
  logic pend_ff, nxt_pend;
  logic [23:0] pend_data_ff, nxt_pend_data;
  logic [3:0] pend_index_ff, nxt_pend_index;
  logic [3:0] busy_ff, nxt_busy;
  logic [7:0] flags_ff, nxt_flags;
  logic [7:0] tag_ff, nxt_tag;
  logic dout_ff, nxt_dout, int_ff, nxt_int;

  logic [CW-1:0] wm_eff;
  logic crc_on, read_active, wr_busy, load_req, wm_hold;
  logic [4:0] sample_last;
  logic [31:0] rd_word;
  logic [11:0] hi_part;
  logic upper_hit, lower_hit;

  assign wm_eff = (watermark_i == 8'h00) ? CW'(DEPTH) : CW'(watermark_i);
  assign crc_on = link_check_enable_i & ~state_append_i & tag_append_i;
  assign sample_last = tag_append_i ? TAGGED_LAST : BARE_LAST;
  assign wr_busy = (busy_ff != 4'h0);
  assign read_active = (phase_ff == PH_CNT) | (phase_ff == PH_DATA) | (phase_ff == PH_CRC);
  assign rd_word = mem[rd_ptr_ff];
  assign hi_part = pend_data_ff[23:12];
  assign upper_hit = limit_check_enable_i[pend_index_ff] & (hi_part > upper_limit_value_i);
  assign lower_hit = limit_check_enable_i[pend_index_ff] & (hi_part < lower_limit_value_i);
  assign wm_hold = ~stream_mode_i & (count_ff < wm_eff);

  // serial readout, write engine and flags
  always_comb begin
    nxt_phase = phase_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_in_sreg = in_sreg_ff;
    nxt_out_sreg = out_sreg_ff;
    nxt_crc = crc_ff;
    nxt_remain = remain_ff;
    nxt_block = block_ff;
    nxt_count = count_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_pend = pend_ff;
    nxt_pend_data = pend_data_ff;
    nxt_pend_index = pend_index_ff;
    nxt_busy = wr_busy ? busy_ff - 4'h1 : busy_ff;
    nxt_flags = flags_ff;
    nxt_tag = tag_ff;
    nxt_dout = dout_ff;
    load_req = 1'b0;
    mem_we = 1'b0;
    mem_wdata = 32'h0000_0000;

    if (cs_high) begin
      // ready level on the data-out pin while deselected
      nxt_phase = PH_IDLE;
      nxt_dout = fifo_enable_i & (wr_busy | wm_hold);
    end else if (cs_fall) begin
      nxt_phase = PH_CMD;
      nxt_bit_cnt = 5'h00;
      nxt_crc = CRC_SEED;
      nxt_out_sreg = 32'h0000_0000;
      nxt_dout = 1'b0;
    end else if (sclk_rise) begin
      nxt_bit_cnt = bit_cnt_ff + 5'h01;
      case (phase_ff)
        PH_CMD: begin
          nxt_in_sreg = {in_sreg_ff[6:0], mosi};
          nxt_crc = crc_step(crc_ff, mosi);
          if (bit_cnt_ff == BYTE_LAST) begin
            nxt_bit_cnt = 5'h00;
            if ({in_sreg_ff[6:0], mosi} == BURST_READ_CMD) begin
              nxt_phase = PH_CNT;
              nxt_out_sreg = state_append_i ? {flags_ff, 24'h000000} : 32'h0000_0000;
            end else if ({in_sreg_ff[6:0], mosi} == FLAGS_READ_CMD) begin
              nxt_phase = PH_STAT;
              nxt_out_sreg = {flags_ff, 24'h000000};
            end else begin
              nxt_phase = PH_IDLE;
            end
          end
        end
        PH_CNT: begin
          nxt_in_sreg = {in_sreg_ff[6:0], mosi};
          nxt_crc = crc_step(crc_ff, mosi);
          if (bit_cnt_ff == BYTE_LAST) begin
            nxt_bit_cnt = 5'h00;
            nxt_remain = ({in_sreg_ff[6:0], mosi} == 8'h00) ? CW'(DEPTH) : CW'({in_sreg_ff[6:0], mosi});
            nxt_block = '0;
            nxt_phase = PH_DATA;
            load_req = 1'b1;
          end
        end
        PH_DATA: begin
          if (bit_cnt_ff == sample_last) begin
            nxt_bit_cnt = 5'h00;
            nxt_remain = remain_ff - CW'(1);
            nxt_block = block_ff + CW'(1);
            if (crc_on && (block_ff + CW'(1) == wm_eff)) begin
              nxt_phase = PH_CRC;
              nxt_block = '0;
              nxt_out_sreg = {crc_ff, 16'h0000};
            end else if (remain_ff == CW'(1)) begin
              nxt_phase = PH_IDLE;
            end else begin
              load_req = 1'b1;
            end
          end
        end
        PH_CRC: begin
          if (bit_cnt_ff == CRC_LAST) begin
            nxt_bit_cnt = 5'h00;
            nxt_crc = CRC_SEED;
            if (remain_ff == '0) begin
              nxt_phase = PH_IDLE;
            end else begin
              nxt_phase = PH_DATA;
              load_req = 1'b1;
            end
          end
        end
        PH_STAT: begin
          if (bit_cnt_ff == BYTE_LAST) begin
            nxt_phase = PH_IDLE;
          end
        end
        default: begin
          nxt_phase = PH_IDLE;
        end
      endcase
    end else if (sclk_fall && (phase_ff != PH_IDLE) && (phase_ff != PH_CMD)) begin
      // shift the next bit out on the falling edge
      nxt_dout = out_sreg_ff[31];
      nxt_out_sreg = {out_sreg_ff[30:0], 1'b0};
      if ((phase_ff == PH_DATA) && crc_on) begin
        nxt_crc = crc_step(crc_ff, out_sreg_ff[31]);
      end
    end

    // fetch the next sample for the shifter
    if (load_req) begin
      if (count_ff == '0) begin
        nxt_out_sreg = 32'h0000_0000;
        nxt_flags[FLAG_DRAINED] = 1'b1;
        nxt_flags[FLAG_READ_CLASH] = 1'b0;
      end else if (wr_busy) begin
        nxt_out_sreg = 32'h0000_0000;
        nxt_flags[FLAG_READ_CLASH] = 1'b1;
      end else begin
        nxt_tag = rd_word[31:24];
        nxt_flags[FLAG_READ_CLASH] = 1'b0;
        nxt_rd_ptr = rd_ptr_ff + AW'(1);
        nxt_count = count_ff - CW'(1);
        if (count_ff == CW'(1)) begin
          nxt_tag[TAG_DRAINED] = tag_append_i;
          nxt_flags[FLAG_DRAINED] = 1'b1;
          nxt_flags[FLAG_LOST] = 1'b0;
          nxt_flags[FLAG_UPPER] = 1'b0;
          nxt_flags[FLAG_LOWER] = 1'b0;
          nxt_flags[FLAG_WRITE_CLASH] = 1'b0;
        end
        nxt_out_sreg = tag_append_i ? {nxt_tag, rd_word[23:0]} : {rd_word[23:0], 8'h00};
      end
    end

    // pending conversion goes in once no read holds the memory and the last write's busy time is over
    if (pend_ff && !read_active && !wr_busy) begin
      nxt_pend = 1'b0;
      nxt_busy = WRITE_BUSY_CYCLES;
      if (!stream_mode_i && (count_ff >= wm_eff)) begin
        nxt_flags[FLAG_WRITE_CLASH] = 1'b1;
        nxt_flags[FLAG_LOST] = 1'b1;
      end else begin
        mem_we = 1'b1;
        nxt_wr_ptr = wr_ptr_ff + AW'(1);
        if (count_ff == CW'(DEPTH)) begin
          nxt_rd_ptr = rd_ptr_ff + AW'(1);
          nxt_flags[FLAG_LOST] = 1'b1;
        end else begin
          nxt_count = count_ff + CW'(1);
        end
        mem_wdata[23:0] = pend_data_ff;
        if (tag_append_i) begin
          mem_wdata[24 + TAG_LIMIT] = upper_hit | lower_hit;
          mem_wdata[24 + TAG_LEVEL] = (nxt_count >= wm_eff);
          mem_wdata[27:24] = pend_index_ff;
        end
        nxt_flags[FLAG_DRAINED] = 1'b0;
        if (upper_hit) begin
          nxt_flags[FLAG_UPPER] = 1'b1;
        end
        if (lower_hit) begin
          nxt_flags[FLAG_LOWER] = 1'b1;
        end
      end
    end

    // capture a new conversion result
    if (conv_valid_i && fifo_enable_i) begin
      if (nxt_pend) begin
        nxt_flags[FLAG_WRITE_CLASH] = 1'b1;
        nxt_flags[FLAG_LOST] = 1'b1;
      end
      nxt_pend = 1'b1;
      nxt_pend_data = conv_data_i;
      nxt_pend_index = input_index_i;
    end

    nxt_flags[FLAG_LEVEL] = (nxt_count >= wm_eff);
    nxt_flags[FLAG_ANY_ERR] = any_error_i;
    nxt_int = fifo_enable_i & |(nxt_flags[6:0] & int_enable_i);
  end

  // memory write port
  always_ff @(posedge sys_clk_i) begin
    if (mem_we) begin
      mem[wr_ptr_ff] <= mem_wdata;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_ff <= PH_IDLE;
      bit_cnt_ff <= 5'h00;
      in_sreg_ff <= 8'h00;
      out_sreg_ff <= 32'h0000_0000;
      crc_ff <= CRC_SEED;
      remain_ff <= '0;
      block_ff <= '0;
      count_ff <= '0;
      rd_ptr_ff <= '0;
      wr_ptr_ff <= '0;
      pend_ff <= 1'b0;
      pend_data_ff <= 24'h000000;
      pend_index_ff <= 4'h0;
      busy_ff <= 4'h0;
      flags_ff <= STATE_FLAGS_RESET;
      tag_ff <= TAG_RESET;
      dout_ff <= 1'b0;
      int_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      bit_cnt_ff <= nxt_bit_cnt;
      in_sreg_ff <= nxt_in_sreg;
      out_sreg_ff <= nxt_out_sreg;
      crc_ff <= nxt_crc;
      remain_ff <= nxt_remain;
      block_ff <= nxt_block;
      count_ff <= nxt_count;
      rd_ptr_ff <= nxt_rd_ptr;
      wr_ptr_ff <= nxt_wr_ptr;
      pend_ff <= nxt_pend;
      pend_data_ff <= nxt_pend_data;
      pend_index_ff <= nxt_pend_index;
      busy_ff <= nxt_busy;
      flags_ff <= nxt_flags;
      tag_ff <= nxt_tag;
      dout_ff <= nxt_dout;
      int_ff <= nxt_int;
    end
  end

  assign dout_o = dout_ff;
  assign fifo_int_o = int_ff;
  assign fifo_state_flags_o = flags_ff;
  assign fifo_sample_tag_o = tag_ff;
endmodule

// *** testbench/adc_sample_fifo_monitor.sv ***
`timescale 1ns/1ps
module adc_sample_fifo_monitor (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic dout_o,
  input wire logic fifo_enable_i,
  input wire logic stream_mode_i,
  input wire logic any_error_i,
  input wire logic conv_valid_i,
  input wire logic [6:0] int_enable_i,
  input wire logic fifo_int_o,
  input wire logic [7:0] fifo_state_flags_o
);
  import adc_fifo_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // enabled sources and sticky flag group
  logic [6:0] live_src;
  logic [4:0] sticky;
  assign live_src = int_enable_i & fifo_state_flags_o[6:0];
  assign sticky = fifo_state_flags_o[6:2];
  // watermark mode, idle long enough for writes to settle
  sequence s_quiet;
    (cs_n_i && fifo_enable_i && !stream_mode_i && !conv_valid_i)[*8] ##1
      (cs_n_i && fifo_enable_i && !stream_mode_i && !conv_valid_i)[*4];
  endsequence
  // accepted conversion with the bus left idle
  sequence s_write;
    (fifo_enable_i && conv_valid_i && (stream_mode_i || !fifo_state_flags_o[FLAG_LEVEL])) ##1 cs_n_i[*8] ##1 cs_n_i;
  endsequence
  sequence s_fresh;
    cs_n_i[*6] ##0 (fifo_enable_i && conv_valid_i) ##1 cs_n_i[*4];
  endsequence
  a_flags_reset: assert property ($rose(arst_n_i) |-> fifo_state_flags_o == STATE_FLAGS_RESET)
    else $error("flags not at reset value");
  a_err_mirror: assert property ($past(arst_n_i) |-> fifo_state_flags_o[FLAG_ANY_ERR] == $past(any_error_i))
    else $error("error bit not mirrored");
  a_int_on: assert property ((fifo_enable_i && live_src != 7'h00)[*3] |-> fifo_int_o)
    else $error("interrupt missing");
  a_int_off: assert property ((live_src == 7'h00)[*3] |-> !fifo_int_o)
    else $error("interrupt without source");
  a_ready_low: assert property (s_quiet ##0 fifo_state_flags_o[FLAG_LEVEL] |-> !dout_o)
    else $error("ready not low at watermark");
  a_write_busy: assert property (s_write |-> dout_o && $past(dout_o, 6))
    else $error("ready not high while writing");
  a_sticky_flags: assert property (cs_n_i[*8] |=> (sticky & $past(sticky)) == $past(sticky))
    else $error("sticky flag fell while idle");
  a_drained_clr: assert property (s_fresh |-> !fifo_state_flags_o[FLAG_DRAINED])
    else $error("drained not cleared by write");
endmodule

bind adc_sample_fifo adc_sample_fifo_monitor u_adc_sample_fifo_monitor (.sys_clk_i, .arst_n_i, .cs_n_i,
  .dout_o, .fifo_enable_i, .stream_mode_i, .any_error_i, .conv_valid_i, .int_enable_i, .fifo_int_o,
  .fifo_state_flags_o);

// *** testbench/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model (
  input wire logic dout_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o
);
  logic [127:0] rx;
  // idle bus, clock parked high
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    rx = '0;
  end
  // frame: command, count, then read bits msb first
  task automatic burst(input logic [7:0] cmd, input logic [7:0] cnt, input int nbits);
    logic [15:0] hdr;
    hdr = {cmd, cnt};
    cs_n_o = 1'b0;
    #40;
    for (int i = 0; i < 16 + nbits; i++) begin
      sclk_o = 1'b0;
      mosi_o = (i < 16) ? hdr[15 - i] : ~mosi_o;
      #40;
      sclk_o = 1'b1;
      rx = {rx[126:0], dout_i};
      #40;
    end
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  import adc_fifo_pkg::*;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic sclk_i, cs_n_i, mosi_i, dout_o, fifo_int_o;
  logic fifo_enable_i = 1'b1;
  logic stream_mode_i = 1'b0;
  logic [7:0] watermark_i = 8'h02;
  logic tag_append_i = 1'b1;
  logic state_append_i = 1'b0;
  logic link_check_enable_i = 1'b1;
  logic [6:0] int_enable_i = 7'h02;
  logic [15:0] limit_check_enable_i = 16'h0020;
  logic [11:0] upper_limit_value_i = 12'h800;
  logic [11:0] lower_limit_value_i = 12'h100;
  logic any_error_i = 1'b0;
  logic conv_valid_i = 1'b0;
  logic [23:0] conv_data_i = 24'h000000;
  logic [3:0] input_index_i = 4'h0;
  logic [7:0] fifo_state_flags_o, fifo_sample_tag_o;
  logic [15:0] crc;
  int fails = 0;
  int samples_checked = 0;
  adc_sample_fifo u_adc_sample_fifo (.sys_clk_i, .arst_n_i, .sclk_i, .cs_n_i, .mosi_i, .dout_o, .fifo_enable_i,
    .stream_mode_i, .watermark_i, .tag_append_i, .state_append_i, .link_check_enable_i, .int_enable_i,
    .limit_check_enable_i, .upper_limit_value_i, .lower_limit_value_i, .any_error_i, .conv_valid_i,
    .conv_data_i, .input_index_i, .fifo_int_o, .fifo_state_flags_o, .fifo_sample_tag_o);
  spi_host_model u_spi_host_model (.dout_i(dout_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i));
  // system clock
  always #2 sys_clk_i = ~sys_clk_i;
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // one conversion pulse, then the minimum spacing
  task automatic conv(input logic [23:0] d, input logic [3:0] idx);
    conv_data_i = d;
    input_index_i = idx;
    conv_valid_i = 1'b1;
    step(1);
    conv_valid_i = 1'b0;
    step(12);
  endtask
  // link check, shift left with feedback from the top bit
  function automatic logic [15:0] crc_upd(logic [15:0] c, logic [63:0] v, int n);
    for (int i = n - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic t_reset();
    `CHK({fifo_state_flags_o, fifo_sample_tag_o}, {STATE_FLAGS_RESET, TAG_RESET})
    `CHK({fifo_int_o, dout_o}, 2'b01)
    $display("t_reset done");
  endtask
  task automatic t_fill();
    conv(24'h900abc, 4'h5);
    `CHK(fifo_state_flags_o, 8'h10)
    `CHK(dout_o, 1'b1)
    conv(24'h123456, 4'h3);
    `CHK(fifo_state_flags_o, 8'h12)
    `CHK({fifo_int_o, dout_o}, 2'b10)
    conv(24'h0000ff, 4'h3);
    `CHK(fifo_state_flags_o, 8'h56)
    int_enable_i = 7'h40;
    step(3);
    `CHK(fifo_int_o, 1'b1)
    int_enable_i = 7'h00;
    any_error_i = 1'b1;
    step(3);
    `CHK({fifo_state_flags_o[7], fifo_int_o}, 2'b10)
    any_error_i = 1'b0;
    int_enable_i = 7'h02;
    step(3);
    $display("t_fill done");
  endtask
  task automatic t_read();
    u_spi_host_model.burst(BURST_READ_CMD, 8'h02, 80);
    step(20);
    `CHK(u_spi_host_model.rx[79:72], 8'h45)
    `CHK(u_spi_host_model.rx[71:48], 24'h900abc)
    `CHK(u_spi_host_model.rx[47:40], 8'h33)
    `CHK(u_spi_host_model.rx[39:16], 24'h123456)
    `CHK(fifo_sample_tag_o, 8'h33)
    crc = crc_upd(CRC_SEED, {48'h0, BURST_READ_CMD, 8'h02}, 16);
    crc = crc_upd(crc, u_spi_host_model.rx[79:16], 64);
    `CHK(u_spi_host_model.rx[15:0], crc)
    `CHK({fifo_state_flags_o, fifo_int_o, dout_o}, 10'h005)
    $display("t_read done");
  endtask
  task automatic t_empty();
    state_append_i = 1'b1;
    u_spi_host_model.burst(BURST_READ_CMD, 8'h01, 32);
    step(20);
    `CHK(u_spi_host_model.rx[39:32], 8'h01)
    `CHK(u_spi_host_model.rx[23:0], 24'h000000)
    `CHK(fifo_state_flags_o, 8'h01)
    $display("t_empty done");
  endtask
  task automatic t_bare();
    state_append_i = 1'b0;
    tag_append_i = 1'b0;
    upper_limit_value_i = 12'habc;
    limit_check_enable_i = 16'h00a0;
    conv(24'habcdef, 4'h7);
    conv(24'h0500ef, 4'h5);
    `CHK(fifo_state_flags_o, 8'h0a)
    u_spi_host_model.burst(BURST_READ_CMD, 8'h02, 48);
    step(20);
    `CHK(u_spi_host_model.rx[47:0], {24'habcdef, 24'h0500ef})
    `CHK(fifo_state_flags_o, 8'h01)
    $display("t_bare done");
  endtask
  // streaming mode: ready pulses busy per conversion, then falls
  task automatic t_stream();
    stream_mode_i = 1'b1;
    conv_data_i = 24'h345678;
    input_index_i = 4'h2;
    conv_valid_i = 1'b1;
    step(1);
    conv_valid_i = 1'b0;
    step(4);
    `CHK(dout_o, 1'b1)
    step(8);
    `CHK({fifo_state_flags_o, dout_o}, 9'h000)
    $display("t_stream done");
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk_i);
    #1;
    arst_n_i = 1'b1;
    step(6);
    t_reset();
    t_fill();
    t_read();
    t_empty();
    t_bare();
    t_stream();
    test_done();
  end
  // hang guard
  initial begin
    repeat (30000) @(posedge sys_clk_i);
    fails++;
    test_done();
  end
endmodule
